// [core/pfsc_regs.svh]
// Timing figures, register map and field positions of the port fault shutdown block.
// What this block does
// R1 - Fast shutdown active high, 1-5 us deglitch
// R2 - Fast shutdown turns off priority-selected ports only
// R3 - Deglitched reset low clears ports and registers
// R4 - Power-on reset acts independent of reset pin
// R5 - Host waits 5 ms before detect commands
// R6 - Semiauto: high port voltage, discharge, 400 ms backoff
// R7 - Detection takes four points, two probe levels
// R8 - Monitor resistor on except detecting or powered
// R9 - Gate low on supply low, timeout, shutdown
// R10 - Fault timer counts up, trips at limit
// R11 - Count down at 1/16, restart needs zero
// R12 - Inrush lowers current limit with port voltage
// R13 - Interrupt pin low while any unmasked flag set
// R14 - Bus address from four strapped select pins
// R15 - Separate serial data in, open-drain out
// R16 - Classification may run on several ports
// R17 - Deglitch filters are clocked stability counters
// R18 - Overcurrent shutdown sets per-port interrupt flag
`ifndef PFSC_REGS_SVH
`define PFSC_REGS_SVH
`define PFSC_CLK_MHZ 50
`define PFSC_DGL_US 1
`define PFSC_DGL_CYC (`PFSC_DGL_US * `PFSC_CLK_MHZ)
`define PFSC_OVLD_US 60
`define PFSC_OVLD_CYC (`PFSC_OVLD_US * `PFSC_CLK_MHZ)
`define PFSC_START_US 60
`define PFSC_START_CYC (`PFSC_START_US * `PFSC_CLK_MHZ)
`define PFSC_DOWN_DIV 16
`define PFSC_INIT_MS 5
`define PFSC_INIT_CYC (`PFSC_INIT_MS * 1000 * `PFSC_CLK_MHZ)
`define PFSC_BACKOFF_MS 400
`define PFSC_BACKOFF_CYC (`PFSC_BACKOFF_MS * 1000 * `PFSC_CLK_MHZ)
`define PFSC_A_CTRL 8'h00
`define PFSC_A_PRIO 8'h04
`define PFSC_A_CLASS 8'h08
`define PFSC_A_DETREQ 8'h0c
`define PFSC_A_STAT 8'h10
`define PFSC_A_IFLAG 8'h14
`define PFSC_A_IMASK 8'h18
`define PFSC_CTRL_SEMI 8
`define PFSC_CTRL_SDA 9
`define PFSC_REG_RST 32'h0000_0000
`define PFSC_SIG_MIN 14'h0100
`define PFSC_SIG_MAX 14'h0400
`define PFSC_SIG_TOL 14'h0020
`define PFSC_PTS 2'h3
`define PFSC_LIM_FULL 2'h3
`endif

// [core/pfsc_pkg.sv]
// Types shared by the port fault shutdown block.
package pfsc_pkg;
    typedef enum logic [1:0] {DET_IDLE, DET_BACKOFF, DET_PROBE, DET_EVAL} pfsc_det_state_t;
    typedef logic [13:0] pfsc_volt_t;
endpackage

// [core/pfsc_deglitch.sv]
// Clocked stability filter for a slow control pin.
`timescale 1ns/1ns
`include "pfsc_regs.svh"
module pfsc_deglitch #(
    parameter int CYC = `PFSC_DGL_CYC,
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw and filtered level
    input wire logic d,
    output logic q
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_q;
    logic q_q;

    assign q = q_q;

    // A new level is taken only after it held for CYC clocks in a row.
    always_ff @(posedge pclk or negedge presetn) begin // [R17] [R1]
        if (!presetn) begin
            cnt_q <= '0;
            q_q <= RST_VAL;
        end else if (d == q_q) begin
            cnt_q <= '0;
        end else if (cnt_q == CW'(CYC - 1)) begin
            cnt_q <= '0;
            q_q <= d;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    a_dgl_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        $changed(q_q) |-> ($past(cnt_q) == CW'(CYC - 1)) && ($past(d) == q_q))
        else $error("Filtered level changed before the hold time.");
endmodule

// [core/pfsc_fault_timer.sv]
// Per-port overcurrent fault timer with slow count-down and inrush foldback.
`timescale 1ns/1ns
`include "pfsc_regs.svh"
module pfsc_fault_timer #(
    parameter int OVLD_CYC = `PFSC_OVLD_CYC,
    parameter int START_CYC = `PFSC_START_CYC,
    parameter int DOWN_DIV = `PFSC_DOWN_DIV
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    // Port state
    input wire logic port_on,
    input wire logic over_cut,
    input wire logic [1:0] droop_code,
    // Results
    output logic trip,
    output logic count_zero,
    output logic in_startup,
    output logic [1:0] limit_code
);
    localparam int MAXC = (OVLD_CYC > START_CYC) ? OVLD_CYC : START_CYC;
    localparam int CW = $clog2(MAXC * DOWN_DIV + DOWN_DIV + 1);
    localparam int SW = $clog2(START_CYC + 1);
    localparam logic [CW-1:0] UP = CW'(DOWN_DIV);
    localparam logic [CW-1:0] OVLD_LIM = CW'(OVLD_CYC * DOWN_DIV);
    localparam logic [CW-1:0] START_LIM = CW'(START_CYC * DOWN_DIV);
    localparam logic [CW-1:0] MAX_LIM = CW'(MAXC * DOWN_DIV);
    logic [CW-1:0] cnt_q;
    logic [SW-1:0] st_q;

    assign in_startup = port_on && (st_q != SW'(START_CYC));
    assign trip = port_on && (cnt_q >= (in_startup ? START_LIM : OVLD_LIM)); // [R10]
    assign count_zero = (cnt_q == '0); // [R11]
    // Higher drop across the switch during inrush gives a lower limit code.
    assign limit_code = in_startup ? ~droop_code : `PFSC_LIM_FULL; // [R12]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else if (clear || !port_on) begin
            st_q <= '0;
        end else if (st_q != SW'(START_CYC)) begin
            st_q <= st_q + 1'b1;
        end
    end

    // Up by DOWN_DIV per clock, down by one: the fall rate is 1/DOWN_DIV.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (port_on && over_cut) begin // [R10]
            cnt_q <= (cnt_q >= MAX_LIM) ? cnt_q : cnt_q + UP;
        end else if (cnt_q != '0) begin // [R11]
            cnt_q <= cnt_q - 1'b1;
        end
    end

    a_trip_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        $rose(trip) && !$past(clear) |-> $past(port_on && over_cut))
        else $error("Fault timer tripped without overcurrent.");
    a_slow_down: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (!clear && !(port_on && over_cut) && cnt_q != '0) |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("Fault counter did not fall by one.");
endmodule

// [core/pfsc_top.sv]
// Port control, fault shutdown, detection sequencing and APB registers.
`timescale 1ns/1ns
`include "pfsc_regs.svh"
module pfsc_top #(
    parameter int NP = 8,
    parameter int INIT_CYC = `PFSC_INIT_CYC,
    parameter int BACKOFF_CYC = `PFSC_BACKOFF_CYC
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins
    input wire logic fast_shutdown_input,
    input wire logic reset_pin_n,
    input wire logic supplies_ok,
    input wire logic [3:0] bus_address_select,
    // Per-port comparators
    input wire logic [NP-1:0] port_over_cut,
    input wire logic [NP-1:0] port_voltage_high,
    input wire logic [2*NP-1:0] port_droop_code,
    // Detection measurement
    input wire logic meas_valid,
    input wire pfsc_pkg::pfsc_volt_t meas_voltage,
    // Port drives
    output logic [NP-1:0] port_gate_drive,
    output logic [NP-1:0] monitor_resistor_en,
    output logic [NP-1:0] discharge_en,
    output logic [NP-1:0] class_en,
    output logic [2*NP-1:0] current_limit_level,
    output logic detect_sink_en,
    output logic detect_probe_high,
    output logic [$clog2(NP)-1:0] detect_port,
    // Serial data and interrupt
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic int_pin_out,
    output logic int_pin_oe,
    output logic irq
);
    import pfsc_pkg::*;

    localparam int PW = $clog2(NP);
    localparam int BW = $clog2(BACKOFF_CYC + 1);
    localparam int IW = $clog2(INIT_CYC + 1);
    localparam int FW = 2 * NP + 1;

    logic shut_lvl, rst_lvl, sys_clear, shut_prev_q;
    logic [NP-1:0] trip, cnt_zero, hit, powered_q, powered_d;
    logic [NP-1:0] port_en_q, prio_q, class_q, detreq_q, det_good_q;
    logic [NP-1:0] dp_hot, det_busy;
    logic [2*NP-1:0] lim_code;
    logic semi_q, sda_q, strap_q, init_win;
    logic [3:0] addr_q;
    logic [IW-1:0] init_q;
    logic [FW-1:0] iflag_q, iflag_d, iflag_set, imask_q, iflag_clr;
    logic pready_q, pslverr_q, rd_ok, acc, wr_acc, rd_acc;
    logic [31:0] prdata_q, rd_mux;
    pfsc_det_state_t st_q, st_d;
    logic [PW-1:0] dp_q, dp_next;
    logic [1:0] pt_q;
    logic [BW-1:0] bo_q;
    pfsc_volt_t v_q [4];
    pfsc_volt_t d1, d2, dd;
    logic det_ok;
    logic [NP-1:0] mon_q, dis_q, cls_q;
    logic [2*NP-1:0] lim_q;
    logic sink_q, irq_q, sdo_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin filters, reset and straps.

    pfsc_deglitch #(.CYC(`PFSC_DGL_CYC), .RST_VAL(1'b0)) u_dgl_shut (
        .pclk(pclk),
        .presetn(presetn),
        .d(fast_shutdown_input),
        .q(shut_lvl)
    );

    pfsc_deglitch #(.CYC(`PFSC_DGL_CYC), .RST_VAL(1'b1)) u_dgl_rst (
        .pclk(pclk),
        .presetn(presetn),
        .d(reset_pin_n),
        .q(rst_lvl)
    );

    // The pin reset is synchronous; presetn is the power-on reset and acts alone.
    assign sys_clear = !rst_lvl; // [R3] [R4]

    // The straps are sampled once after any reset, never under the async reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_q <= 1'b0;
            addr_q <= '0;
        end else if (sys_clear) begin
            strap_q <= 1'b0;
        end else if (!strap_q) begin
            strap_q <= 1'b1;
            addr_q <= bus_address_select; // [R14]
        end
    end

    // Software sees when the start-up settling period is over.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= '0;
        end else if (sys_clear) begin
            init_q <= '0;
        end else if (init_win) begin
            init_q <= init_q + 1'b1;
        end
    end
    assign init_win = (init_q != IW'(INIT_CYC)); // [R5]

    ////////////////////////////////////////////////////////////////////////////
    // Fault timers and port power.

    for (genvar i = 0; i < NP; i++) begin : g_port
        pfsc_fault_timer u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .clear(sys_clear),
            .port_on(powered_q[i]),
            .over_cut(port_over_cut[i]),
            .droop_code(port_droop_code[2*i +: 2]),
            .trip(trip[i]),
            .count_zero(cnt_zero[i]),
            .in_startup(),
            .limit_code(lim_code[2*i +: 2])
        );
    end

    assign hit = {NP{shut_lvl}} & prio_q; // [R2]
    // A port stays on only while enabled, untripped and supplied; it starts only
    // once its fault counter has drained to zero.
    assign powered_d = ((powered_q & port_en_q & ~trip) | (~powered_q & port_en_q & cnt_zero))
                       & ~hit & {NP{supplies_ok}}; // [R9] [R11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_q <= '0;
        end else if (sys_clear) begin
            powered_q <= '0; // [R3]
        end else begin
            powered_q <= powered_d;
        end
    end
    assign port_gate_drive = powered_q;

    ////////////////////////////////////////////////////////////////////////////
    // Detection sequencer, one port at a time in semiautomatic mode.

    assign dp_next = (dp_q == PW'(NP - 1)) ? '0 : dp_q + 1'b1;
    assign dp_hot = NP'(1) << dp_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            DET_IDLE: begin
                if (semi_q && detreq_q[dp_q] && !powered_q[dp_q]) begin
                    st_d = port_voltage_high[dp_q] ? DET_BACKOFF : DET_PROBE; // [R6]
                end
            end
            DET_BACKOFF: begin
                if (bo_q == BW'(BACKOFF_CYC - 1)) begin
                    st_d = DET_PROBE; // [R6]
                end
            end
            DET_PROBE: begin
                if (meas_valid && pt_q == `PFSC_PTS) begin
                    st_d = DET_EVAL; // [R7]
                end
            end
            DET_EVAL: begin
                st_d = DET_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= DET_IDLE;
            dp_q <= '0;
            pt_q <= '0;
            bo_q <= '0;
        end else if (sys_clear) begin
            st_q <= DET_IDLE;
            dp_q <= '0;
            pt_q <= '0;
            bo_q <= '0;
        end else begin
            st_q <= st_d;
            if ((st_q == DET_IDLE && st_d == DET_IDLE) || st_q == DET_EVAL) begin
                dp_q <= dp_next;
            end
            bo_q <= (st_q == DET_BACKOFF) ? bo_q + 1'b1 : '0;
            // Points alternate low and high probe current. [R7]
            if (st_q == DET_PROBE && meas_valid) begin
                pt_q <= pt_q + 1'b1;
            end else if (st_q != DET_PROBE) begin
                pt_q <= '0;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (st_q == DET_PROBE && meas_valid) begin
            v_q[pt_q] <= meas_voltage;
        end
    end

    // Equal slopes at both probe pairs reject a capacitive or legacy load.
    assign d1 = v_q[1] - v_q[0];
    assign d2 = v_q[3] - v_q[2];
    assign dd = (d1 > d2) ? d1 - d2 : d2 - d1;
    assign det_ok = (v_q[1] > v_q[0]) && (v_q[3] > v_q[2]) && (d1 >= `PFSC_SIG_MIN)
                    && (d1 <= `PFSC_SIG_MAX) && (dd <= `PFSC_SIG_TOL); // [R7]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_good_q <= '0;
        end else if (sys_clear) begin
            det_good_q <= '0;
        end else if (st_q == DET_EVAL) begin
            det_good_q[dp_q] <= det_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, answer registered in the setup cycle.

    assign acc = psel && penable && pready_q;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;

    always_comb begin
        rd_ok = 1'b1;
        unique case (paddr)
            `PFSC_A_CTRL: rd_mux = {22'h0, sda_q, semi_q, 8'(port_en_q)};
            `PFSC_A_PRIO: rd_mux = 32'(prio_q);
            `PFSC_A_CLASS: rd_mux = 32'(class_q);
            `PFSC_A_DETREQ: rd_mux = 32'(detreq_q);
            `PFSC_A_STAT: rd_mux = {9'h0, shut_lvl, serial_data_in, init_win, addr_q,
                                    8'(det_good_q), 8'(powered_q)};
            `PFSC_A_IFLAG: rd_mux = 32'(iflag_q);
            `PFSC_A_IMASK: rd_mux = 32'(imask_q);
            default: begin
                rd_mux = `PFSC_REG_RST;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `PFSC_REG_RST;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !rd_ok;
            if (psel && !penable) begin
                prdata_q <= pwrite ? `PFSC_REG_RST : rd_mux;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Shutdown and overcurrent drop the enable, as a port reset command would.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_en_q <= '0;
            semi_q <= 1'b0;
            sda_q <= 1'b0;
        end else if (sys_clear) begin
            port_en_q <= '0; // [R3]
            semi_q <= 1'b0;
            sda_q <= 1'b0;
        end else begin
            if (wr_acc && paddr == `PFSC_A_CTRL) begin
                port_en_q <= pwdata[NP-1:0] & ~hit & ~(trip & powered_q);
                semi_q <= pwdata[`PFSC_CTRL_SEMI];
                sda_q <= pwdata[`PFSC_CTRL_SDA];
            end else begin
                port_en_q <= port_en_q & ~hit & ~(trip & powered_q); // [R2] [R9]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_q <= '0;
            class_q <= '0;
            detreq_q <= '0;
            imask_q <= '0;
        end else if (sys_clear) begin
            prio_q <= '0;
            class_q <= '0;
            detreq_q <= '0;
            imask_q <= '0;
        end else begin
            if (wr_acc && paddr == `PFSC_A_PRIO) begin
                prio_q <= pwdata[NP-1:0];
            end
            if (wr_acc && paddr == `PFSC_A_CLASS) begin
                class_q <= pwdata[NP-1:0];
            end
            if (wr_acc && paddr == `PFSC_A_IMASK) begin
                imask_q <= pwdata[FW-1:0];
            end
            if (wr_acc && paddr == `PFSC_A_DETREQ) begin
                detreq_q <= pwdata[NP-1:0];
            end else if (st_q == DET_EVAL) begin
                detreq_q <= detreq_q & ~dp_hot;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags: read clears only what the read returned; a new event wins.

    assign iflag_set = {shut_lvl && !shut_prev_q,
                        (st_q == DET_EVAL) ? dp_hot : NP'(0),
                        trip & powered_q}; // [R18]
    assign iflag_clr = (rd_acc && paddr == `PFSC_A_IFLAG) ? prdata_q[FW-1:0] : '0;
    assign iflag_d = (iflag_q & ~iflag_clr) | iflag_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iflag_q <= '0;
            shut_prev_q <= 1'b0;
        end else if (sys_clear) begin
            iflag_q <= '0;
            shut_prev_q <= 1'b0;
        end else begin
            iflag_q <= iflag_d;
            shut_prev_q <= shut_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin drives.

    assign det_busy = (st_d == DET_PROBE || st_d == DET_EVAL) ? dp_hot : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_q <= '1;
            dis_q <= '0;
            cls_q <= '0;
            lim_q <= '0;
            sink_q <= 1'b0;
            irq_q <= 1'b0;
            sdo_q <= 1'b0;
        end else begin
            mon_q <= ~(powered_d | det_busy); // [R8]
            dis_q <= (st_d == DET_BACKOFF) ? dp_hot : '0; // [R6]
            // Classes run through each port's own switch, so no port excludes another.
            cls_q <= class_q & ~powered_d; // [R16]
            lim_q <= lim_code; // [R12]
            sink_q <= (st_d == DET_PROBE); // [R7]
            irq_q <= |(iflag_d & imask_q); // [R13]
            sdo_q <= sda_q; // [R15]
        end
    end

    assign monitor_resistor_en = mon_q;
    assign discharge_en = dis_q;
    assign class_en = cls_q;
    assign current_limit_level = lim_q;
    assign detect_sink_en = sink_q;
    assign detect_probe_high = pt_q[0];
    assign detect_port = dp_q;
    assign serial_data_out = 1'b0;
    assign serial_data_out_oe = sdo_q;
    assign int_pin_out = 1'b0;
    assign int_pin_oe = irq_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_shut_prio: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (shut_lvl && |(prio_q & powered_q)) |=> (powered_q & $past(prio_q)) == '0)
        else $error("Selected port stayed on under fast shutdown.");
    a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        !rst_lvl |=> (port_en_q == '0) && (powered_q == '0) && (imask_q == '0))
        else $error("Pin reset did not clear ports and registers.");
    a_supply_off: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !supplies_ok |=> port_gate_drive == '0)
        else $error("Gate driven while a supply is low.");
    a_backoff_len: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        (st_q == DET_PROBE && $past(st_q) == DET_BACKOFF)
        |-> $past(bo_q) == BW'(BACKOFF_CYC - 1) && $past(discharge_en) != '0)
        else $error("Backoff ended at the wrong count.");
    a_four_points: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        st_q == DET_EVAL |-> $past(pt_q) == `PFSC_PTS && $past(meas_valid))
        else $error("Detection evaluated without four points.");
    a_mon_res: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (monitor_resistor_en & port_gate_drive) == '0)
        else $error("Monitor resistor on while port powered.");
    a_int_pin: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (|(iflag_q & imask_q)) && !rd_acc && !wr_acc |=> int_pin_oe && irq)
        else $error("Interrupt pin released with a flag set.");
    a_ocp_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        (|(trip & powered_q)) && !sys_clear
        |=> (iflag_q[NP-1:0] & $past(trip & powered_q)) == $past(trip & powered_q))
        else $error("Overcurrent shutdown left its flag clear.");
endmodule

// [test/pfsc_host_model.sv]
// Far-side host model: the joined serial data line with its pull-up.
`timescale 1ns/1ns
module pfsc_host_model (
    // Device side of the split data pins
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    // Host side
    input wire logic host_pull_low,
    output logic serial_data_in
);
    // In and out pins are joined as a non-isolated system would wire them.
    // The pull-up wins unless some party sinks the line.
    assign serial_data_in = !(serial_data_out_oe && !serial_data_out) && !host_pull_low;
endmodule

// [test/test_pfsc_top.sv]
// Self-checking bench for the port fault shutdown block.
`timescale 1ns/1ns
`include "pfsc_regs.svh"
module test_pfsc_top;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d, m, x; logic e;} pfsc_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, fsi = 0, rpin_n = 1, sup = 1, sdi, sdo, sdo_oe, irq;
    logic [7:0] ocut = 8'h00, gate, mon, dis, pvh = 8'h00;
    logic mval = 0;
    logic [13:0] mv = 14'h0;
    int fails = 0, n_checks = 0, cyc = 0;
    pfsc_row_t rows[11] = '{
        '{1, `PFSC_A_PRIO, 32'hff, 0, 0, 0}, '{0, `PFSC_A_PRIO, 0, '1, 32'hff, 0},
        '{1, 8'h1c, 32'h5, 0, 0, 1}, '{0, 8'h1c, 0, '1, 0, 1},
        '{1, `PFSC_A_IMASK, 32'h1ffff, 0, 0, 0}, '{0, `PFSC_A_IMASK, 0, '1, 32'h1ffff, 0},
        '{1, `PFSC_A_CTRL, 32'h200, 0, 0, 0}, '{0, `PFSC_A_STAT, 0, 32'h2f0000, 32'h0a0000, 0},
        '{1, `PFSC_A_CTRL, 32'h0, 0, 0, 0}, '{0, `PFSC_A_STAT, 0, 32'h2f0000, 32'h2a0000, 0},
        '{1, `PFSC_A_STAT, '1, 0, 0, 0}};
    always #10 pclk = ~pclk;
    pfsc_top #(.NP(8), .INIT_CYC(20), .BACKOFF_CYC(16)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_shutdown_input(fsi),
        .reset_pin_n(rpin_n), .supplies_ok(sup), .bus_address_select(4'ha),
        .port_over_cut(ocut), .port_voltage_high(pvh), .port_droop_code(16'h0000),
        .meas_valid(mval), .meas_voltage(mv), .port_gate_drive(gate),
        .monitor_resistor_en(mon), .discharge_en(dis), .class_en(), .current_limit_level(),
        .detect_sink_en(), .detect_probe_high(), .detect_port(), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .int_pin_out(), .int_pin_oe(),
        .irq(irq));
    pfsc_host_model host (.serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
        .host_pull_low(1'b0), .serial_data_in(sdi));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(negedge pclk);
    endtask
    // A hang is cut short here; the whole run needs about 52000 cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 70000) begin fails++; tally_and_finish; end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        wcyc(3);
        chk({irq, gate, mon}, {1'b0, 8'h00, 8'hff});
        @(posedge pclk) presetn <= 1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk({r & rows[i].m, 31'h0, e}, {rows[i].x, 31'h0, rows[i].e});
        end
        apb(1, `PFSC_A_PRIO, 32'h01);
        apb(1, `PFSC_A_CTRL, 32'h03);
        @(posedge pclk) fsi <= 1;
        repeat (10) @(posedge pclk);
        fsi <= 0;
        wcyc(60);
        chk(gate, 8'h03);
        @(posedge pclk) fsi <= 1;
        wcyc(40);
        chk(gate, 8'h03);
        wcyc(20);
        chk(gate, 8'h02);
        chk(irq, 1);
        @(posedge pclk) fsi <= 0;
        apb(0, `PFSC_A_CTRL, 0);
        chk(r, 32'h02);
        apb(0, `PFSC_A_IFLAG, 0);
        chk(r, 32'h10000);
        @(posedge pclk) sup <= 0;
        wcyc(2);
        chk(gate, 8'h00);
        @(posedge pclk) sup <= 1;
        wcyc(2);
        chk({gate, mon}, {8'h02, 8'hfd});
        @(posedge pclk) ocut <= 8'h02;
        wcyc(2990);
        chk(gate, 8'h02);
        wcyc(20);
        chk({irq, gate}, {1'b1, 8'h00});
        apb(0, `PFSC_A_IFLAG, 0);
        chk(r, 32'h02);
        ocut <= 8'h00;
        wcyc(2);
        chk(irq, 0);
        // The count drains sixteen times slower than it filled, so it needs some 48000 cycles.
        apb(1, `PFSC_A_CTRL, 32'h02);
        wcyc(47000);
        chk(gate, 8'h00);
        wcyc(1500);
        chk(gate, 8'h02);
        @(posedge pclk) pvh <= 8'h01;
        apb(1, `PFSC_A_CTRL, 32'h102);
        apb(1, `PFSC_A_DETREQ, 32'h01);
        wcyc(12);
        chk(dis, 8'h01);
        wcyc(28);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk) mval <= 1;
            mv <= {4'h0, k[0], k[1], 8'h00};
        end
        @(posedge pclk) mval <= 0;
        wcyc(2);
        apb(0, `PFSC_A_STAT, 0);
        chk(r & 32'h10ff00, 32'h100);
        apb(0, `PFSC_A_IFLAG, 0);
        chk(r, 32'h100);
        @(posedge pclk) rpin_n <= 0;
        wcyc(60);
        chk({gate, mon}, {8'h00, 8'hff});
        @(posedge pclk) rpin_n <= 1;
        wcyc(60);
        apb(0, `PFSC_A_CTRL, 0);
        chk(r, 32'h0);
        tally_and_finish;
    end
endmodule
